// >>> rtl/acs_chan_decode.sv
// Decode of the channel select field into analog routing selects
`timescale 1ns/10ps
module acs_chan_decode
	import acs_pkg::*;
(
	// Selected channel
	input wire logic [CH_W-1:0] chan,
	// Routing selects
	output logic [NPIN-1:0] pinSel,
	output logic gndTie,
	output logic tempSel,
	output logic bandgapSel,
	output logic refHiSel,
	output logic refLoSel,
	output logic powered
);
	// One source at most; reserved codes leave every source select low but keep powered high
	always_comb begin
		pinSel = '0;
		gndTie = 1'b0;
		tempSel = 1'b0;
		bandgapSel = 1'b0;
		refHiSel = 1'b0;
		refLoSel = 1'b0;
		powered = (chan != CH_OFF); // R07
		if (acs_is_pin(chan)) begin
			pinSel[chan[2:0]] = 1'b1; // R02
		end else if (acs_is_gnd(chan)) begin
			gndTie = 1'b1; // R03
		end else if (chan == CH_TEMP) begin
			tempSel = 1'b1; // R12
		end else if (chan == CH_BANDGAP) begin
			bandgapSel = 1'b1;
		end else if (chan == CH_REF_HI) begin
			refHiSel = 1'b1; // R05
		end else if (chan == CH_REF_LO) begin
			refLoSel = 1'b1; // R06
		end
		// Reserved codes float the input, so the result is undefined R04
	end
endmodule

// >>> rtl/acs_pkg.sv
// Shared constants, register map and channel helpers for the converter channel select block
package acs_pkg;
	// Datapath widths
	localparam int CH_W = 5;
	localparam int RES_W = 10;
	localparam int NPIN = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BIT_IDX_W = 4;

	// Channel select codes
	localparam logic [CH_W-1:0] CH_PIN_LAST = 5'h07;
	localparam logic [CH_W-1:0] CH_GND_FIRST = 5'h08;
	localparam logic [CH_W-1:0] CH_GND_LAST = 5'h13;
	localparam logic [CH_W-1:0] CH_TEMP = 5'h1A;
	localparam logic [CH_W-1:0] CH_BANDGAP = 5'h1B;
	localparam logic [CH_W-1:0] CH_REF_HI = 5'h1D;
	localparam logic [CH_W-1:0] CH_REF_LO = 5'h1E;
	localparam logic [CH_W-1:0] CH_OFF = 5'h1F;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_STATCTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PINCTL1 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PINCTL2 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PINCTL3 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PINCTL4 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_TRIGCTL = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PWRCTL = 8'h1C;

	// Field positions
	localparam int SC_CH_LSB = 0;
	localparam int SC_CONT_BIT = 5;
	localparam int SC_DONE_BIT = 7;
	localparam int TRIG_SEL_BIT = 0;
	localparam int PWR_BANDGAP_BUFFER_ENABLE_BIT = 0;

	// Reset values
	localparam logic [CH_W-1:0] RST_CHANNEL = CH_OFF;
	localparam logic [NPIN-1:0] RST_PINCTL = 8'h00;
	localparam logic [RES_W-1:0] RST_RESULT = 10'h000;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

	// Timing: one successive approximation step per divider pulse
	localparam int CLK_MHZ = 250;
	localparam int STEP_NS = 40;
	localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int DIV_W = 8;

	// SAR engine states
	typedef enum logic [1:0] {
		SAR_IDLE = 2'b01,
		SAR_TRIAL = 2'b10
	} acs_sar_t;

	function automatic logic acs_is_gnd(input logic [CH_W-1:0] ch);
		acs_is_gnd = (ch >= CH_GND_FIRST) && (ch <= CH_GND_LAST);
	endfunction

	function automatic logic acs_is_pin(input logic [CH_W-1:0] ch);
		acs_is_pin = (ch <= CH_PIN_LAST);
	endfunction
endpackage

// >>> rtl/acs_sar_engine.sv
// Successive approximation sequencer driving the trial code and capturing the result
`timescale 1ns/10ps
module acs_sar_engine
	import acs_pkg::*;
#(
	parameter int RES_BITS = RES_W
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic stepEn,
	input wire logic compHi,
	// Results
	output logic [RES_BITS-1:0] dacCode,
	output logic [RES_BITS-1:0] result,
	output logic done,
	output logic busy
);
	acs_sar_t state_r, state_nxt;
	logic [BIT_IDX_W-1:0] bitIdx_r, bitIdx_nxt;
	logic [RES_BITS-1:0] code_r, code_nxt;
	logic [RES_BITS-1:0] result_r, result_nxt;
	logic done_r, done_nxt;
	logic busy_r, busy_nxt;

	// One bit decided per step, most significant first R01
	always_comb begin
		state_nxt = state_r;
		bitIdx_nxt = bitIdx_r;
		code_nxt = code_r;
		result_nxt = result_r;
		done_nxt = 1'b0;
		if (abort) begin
			state_nxt = SAR_IDLE;
			code_nxt = '0;
		end else if (start) begin
			// A new start always wins over a running trial
			state_nxt = SAR_TRIAL;
			bitIdx_nxt = BIT_IDX_W'(RES_BITS - 1);
			code_nxt = '0;
			code_nxt[RES_BITS-1] = 1'b1;
		end else begin
			unique case (state_r)
				SAR_IDLE: begin
				end
				SAR_TRIAL: begin
					if (stepEn) begin
						code_nxt[bitIdx_r] = compHi;
						if (bitIdx_r == '0) begin
							result_nxt = code_nxt;
							done_nxt = 1'b1;
							state_nxt = SAR_IDLE;
						end else begin
							bitIdx_nxt = bitIdx_r - 1'b1;
							code_nxt[bitIdx_r - 1'b1] = 1'b1;
						end
					end
				end
				default: begin
					state_nxt = SAR_IDLE;
				end
			endcase
		end
		busy_nxt = (state_nxt == SAR_TRIAL);
	end

	// Sequencer registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= SAR_IDLE;
			bitIdx_r <= '0;
			code_r <= '0;
			result_r <= '0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bitIdx_r <= bitIdx_nxt;
			code_r <= code_nxt;
			result_r <= result_nxt;
			done_r <= done_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign dacCode = code_r;
	assign result = result_r;
	assign done = done_r;
	assign busy = busy_r;
endmodule

// >>> rtl/acs_top.sv
// Converter channel select, control registers and APB slave
// Function
// R01: Converter yields a ten bit result by successive approximation as on-chip peripheral.
// R02: Codes 0 to 7 route the eight external pins in ascending order.
// R03: Ninth through twentieth codes tie input to ground, result reads zero.
// R04: Reserved codes give an undefined result; nothing is guaranteed.
// R05: Code 11101 connects the high reference, equal to supply.
// R06: Code 11110 connects the low reference, equal to ground.
// R07: Code 11111 disables the converter with no input connected.
// R08: Software sets the bandgap buffer enable before converting the bandgap channel.
// R09: No hardware trigger; only software starts conversions, trigger setting is ignored.
// R10: Fourth pin control register is reserved and affects no pin.
// R11: Control bits of absent channels are reserved without any effect.
// R12: Code 11010 routes the on-chip temperature sensor.
// R13: Writing the first status register aborts and restarts, unless channel is all ones. The code also aborts without restart for ground codes.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module acs_top
	import acs_pkg::*;
#(
	parameter int STEP_CYCLES = STEP_CYC
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog routing
	output logic [NPIN-1:0] anaPinSel,
	output logic anaGndTie,
	output logic anaTempSel,
	output logic anaBandgapSel,
	output logic anaRefHiSel,
	output logic anaRefLoSel,
	output logic adcPowered,
	output logic bgBufEn,
	output logic [NPIN-1:0] pinDigDisable,
	// Comparator and trial code
	input wire logic compIn,
	output logic [RES_W-1:0] dacCode,
	output logic convBusy
);
	// Register state
	logic [CH_W-1:0] chan_r, chan_nxt;
	logic cont_r, cont_nxt;
	logic done_r, done_nxt;
	logic [RES_W-1:0] result_r, result_nxt;
	logic [NPIN-1:0] pinCtl_r, pinCtl_nxt;
	logic trigSel_r, trigSel_nxt;
	logic bandgap_buffer_enable_r, bandgap_buffer_enable_nxt;
	logic [DATA_W-1:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	// Routing state
	logic [NPIN-1:0] pinSel_r;
	logic gndTie_r, tempSel_r, bgSel_r, refHi_r, refLo_r, powered_r;
	logic [NPIN-1:0] decPin;
	logic decGnd, decTemp, decBg, decRefHi, decRefLo, decPowered;
	// Comparator synchroniser
	logic cmpS1_r, cmpS2_r, cmpS3_r, cmpF_r, cmpF_nxt;
	// Step divider
	logic [DIV_W-1:0] divCnt_r, divCnt_nxt;
	logic stepEn_r, stepEn_nxt;
	// Engine link
	logic engStart, engAbort, engDone, engBusy;
	logic [RES_W-1:0] engResult;
	logic apbWr, apbRd, apbSetup, wrSc, rdRes, mapped;
	logic [CH_W-1:0] wrCh;
	logic wrConv, wrGnd, contRestart;

	// Bus phase decode; a write lands only at the edge where pready is seen high
	assign apbSetup = psel & ~penable;
	assign apbWr = psel & penable & pready_r & pwrite;
	assign apbRd = psel & penable & pready_r & ~pwrite;
	assign wrSc = apbWr && (paddr == OFS_STATCTRL);
	assign rdRes = apbRd && (paddr == OFS_RESULT);
	assign wrCh = pwdata[SC_CH_LSB +: CH_W];
	assign wrGnd = acs_is_gnd(wrCh);
	assign wrConv = (wrCh != CH_OFF) && !wrGnd;
	assign mapped = (paddr == OFS_STATCTRL) || (paddr == OFS_RESULT) || (paddr == OFS_PINCTL1) ||
		(paddr == OFS_PINCTL2) || (paddr == OFS_PINCTL3) || (paddr == OFS_PINCTL4) ||
		(paddr == OFS_TRIGCTL) || (paddr == OFS_PWRCTL);

	// Starts come from software writes or continuous repeat only R09
	assign contRestart = engDone && cont_r && !wrSc;
	assign engStart = (wrSc && wrConv) || contRestart; // R13
	assign engAbort = wrSc && !wrConv; // R13

	// Register file next state and read data
	always_comb begin
		chan_nxt = chan_r;
		cont_nxt = cont_r;
		done_nxt = done_r;
		result_nxt = result_r;
		pinCtl_nxt = pinCtl_r;
		trigSel_nxt = trigSel_r;
		bandgap_buffer_enable_nxt = bandgap_buffer_enable_r;
		// Clears first, so a completion in the same cycle still sets the flag
		if (wrSc || rdRes) begin
			done_nxt = 1'b0;
		end
		if (apbWr) begin
			unique case (paddr)
				OFS_STATCTRL: begin
					chan_nxt = wrCh;
					cont_nxt = pwdata[SC_CONT_BIT];
				end
				OFS_PINCTL1: pinCtl_nxt = pwdata[NPIN-1:0];
				// Stored for readback only; nothing downstream reads it R09
				OFS_TRIGCTL: trigSel_nxt = pwdata[TRIG_SEL_BIT];
				OFS_PWRCTL: bandgap_buffer_enable_nxt = pwdata[PWR_BANDGAP_BUFFER_ENABLE_BIT];
				// Pin controls for absent channels drop the write R10 R11
				default: begin
				end
			endcase
		end
		if (wrSc && wrGnd) begin
			result_nxt = RST_RESULT; // R03
			done_nxt = 1'b1;
		end else if (engDone) begin
			// Completion already latched in the engine, so a same-cycle write other than a ground code cannot cancel it
			result_nxt = engResult; // R01
			done_nxt = 1'b1;
		end
		// Read data is built in the setup cycle so it leaves a flip-flop
		pready_nxt = apbSetup;
		pslverr_nxt = apbSetup && !mapped;
		prdata_nxt = RD_ZERO;
		if (apbSetup && !pwrite) begin
			unique case (paddr)
				OFS_STATCTRL: begin
					prdata_nxt[SC_CH_LSB +: CH_W] = chan_r;
					prdata_nxt[SC_CONT_BIT] = cont_r;
					prdata_nxt[SC_DONE_BIT] = done_r;
				end
				OFS_RESULT: prdata_nxt[RES_W-1:0] = result_r;
				OFS_PINCTL1: prdata_nxt[NPIN-1:0] = pinCtl_r;
				OFS_TRIGCTL: prdata_nxt[TRIG_SEL_BIT] = trigSel_r;
				OFS_PWRCTL: prdata_nxt[PWR_BANDGAP_BUFFER_ENABLE_BIT] = bandgap_buffer_enable_r;
				default: prdata_nxt = RD_ZERO; // R10 R11
			endcase
		end
	end

	// Register file flip-flops
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chan_r <= RST_CHANNEL;
			cont_r <= 1'b0;
			done_r <= 1'b0;
			result_r <= RST_RESULT;
			pinCtl_r <= RST_PINCTL;
			trigSel_r <= 1'b0;
			bandgap_buffer_enable_r <= 1'b0;
			prdata_r <= RD_ZERO;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			chan_r <= chan_nxt;
			cont_r <= cont_nxt;
			done_r <= done_nxt;
			result_r <= result_nxt;
			pinCtl_r <= pinCtl_nxt;
			trigSel_r <= trigSel_nxt;
			bandgap_buffer_enable_r <= bandgap_buffer_enable_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Channel decode, registered one cycle after the field changes
	acs_chan_decode acs_chan_decode_i (
		.chan(chan_r),
		.pinSel(decPin),
		.gndTie(decGnd),
		.tempSel(decTemp),
		.bandgapSel(decBg),
		.refHiSel(decRefHi),
		.refLoSel(decRefLo),
		.powered(decPowered)
	);

	// Routing flip-flops keep the analog selects glitch free
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinSel_r <= '0;
			gndTie_r <= 1'b0;
			tempSel_r <= 1'b0;
			bgSel_r <= 1'b0;
			refHi_r <= 1'b0;
			refLo_r <= 1'b0;
			powered_r <= 1'b0;
		end else begin
			pinSel_r <= decPin; // R02
			gndTie_r <= decGnd;
			tempSel_r <= decTemp; // R12
			bgSel_r <= decBg;
			refHi_r <= decRefHi; // R05
			refLo_r <= decRefLo; // R06
			powered_r <= decPowered; // R07
		end
	end

	// Comparator filter: a change counts once stages two and three agree
	always_comb begin
		cmpF_nxt = cmpF_r;
		if (cmpS2_r == cmpS3_r) begin
			cmpF_nxt = cmpS3_r;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmpS1_r <= 1'b0;
			cmpS2_r <= 1'b0;
			cmpS3_r <= 1'b0;
			cmpF_r <= 1'b0;
		end else begin
			cmpS1_r <= compIn;
			cmpS2_r <= cmpS1_r;
			cmpS3_r <= cmpS2_r;
			cmpF_r <= cmpF_nxt;
		end
	end

	// Step divider restarts with each conversion so every bit gets a full settle
	always_comb begin
		divCnt_nxt = divCnt_r + 1'b1;
		stepEn_nxt = 1'b0;
		if (engStart || (divCnt_r == DIV_W'(STEP_CYCLES - 1))) begin
			divCnt_nxt = '0;
		end
		if (!engStart && (divCnt_r == DIV_W'(STEP_CYCLES - 2))) begin
			stepEn_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			divCnt_r <= '0;
			stepEn_r <= 1'b0;
		end else begin
			divCnt_r <= divCnt_nxt;
			stepEn_r <= stepEn_nxt;
		end
	end

	acs_sar_engine #(
		.RES_BITS(RES_W)
	) acs_sar_engine_i (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(engStart),
		.abort(engAbort),
		.stepEn(stepEn_r),
		.compHi(cmpF_r),
		.dacCode(dacCode),
		.result(engResult),
		.done(engDone),
		.busy(engBusy)
	);

	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign anaPinSel = pinSel_r;
	assign anaGndTie = gndTie_r;
	assign anaTempSel = tempSel_r;
	assign anaBandgapSel = bgSel_r;
	assign anaRefHiSel = refHi_r;
	assign anaRefLoSel = refLo_r;
	assign adcPowered = powered_r;
	assign bgBufEn = bandgap_buffer_enable_r; // R08
	assign pinDigDisable = pinCtl_r;
	assign convBusy = engBusy;

	// Checks
	localparam int CONV_MAX = 400;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence scWriteConv;
		wrSc && wrConv;
	endsequence
	sequence convRuns;
		engBusy ##[1:CONV_MAX] engDone;
	endsequence

	conv_completes_a: assert property (scWriteConv |=> convRuns) // R01
		else $error("conversion did not finish in time");
	pin_route_a: assert property (acs_is_pin(chan_r) |=> anaPinSel == (8'h01 << $past(chan_r[2:0]))) // R02
		else $error("external pin select wrong");
	gnd_zero_a: assert property (wrSc && wrGnd |=> done_r && result_r == RST_RESULT && !engBusy) // R03
		else $error("ground channel did not read zero");
	ref_hi_a: assert property (chan_r == CH_REF_HI |=> anaRefHiSel && anaPinSel == '0 && !anaRefLoSel) // R05
		else $error("high reference not routed");
	ref_lo_a: assert property (chan_r == CH_REF_LO |=> anaRefLoSel && !anaRefHiSel && !anaGndTie) // R06
		else $error("low reference not routed");
	off_disable_a: assert property (wrSc && wrCh == CH_OFF |=> !engBusy ##1 !adcPowered && anaPinSel == '0) // R07
		else $error("disable code left converter active");
	sw_start_only_a: assert property ($rose(engBusy) |-> $past(wrSc) || $past(engDone && cont_r)) // R09
		else $error("conversion started without software");
	pinctl4_inert_a: assert property (apbWr && paddr == OFS_PINCTL4 |=> $stable(pinDigDisable)) // R10
		else $error("reserved pin control changed pins");
	absent_read_a: assert property (apbRd && (paddr == OFS_PINCTL2 || paddr == OFS_PINCTL3) |-> prdata == RD_ZERO) // R11
		else $error("absent channel bits read nonzero");
	temp_route_a: assert property (chan_r == CH_TEMP |=> anaTempSel && !anaBandgapSel) // R12
		else $error("temperature sensor not routed");
	restart_a: assert property (engBusy && wrSc && wrConv |=> engBusy && dacCode == 10'h200) // R13
		else $error("write did not restart conversion");
endmodule

// >>> test/acs_analog_model.sv
// Analog sources and comparator seen by the converter channel select block
`timescale 1ns/10ps
module acs_analog_model
	import acs_pkg::*;
#(
	parameter logic [RES_W-1:0] TEMP_LVL = 10'h155,
	parameter logic [RES_W-1:0] BG_LVL = 10'h2AA
)
(
	// Clock
	input wire logic ref_clk,
	// Routing selects from the block
	input wire logic [NPIN-1:0] anaPinSel,
	input wire logic anaGndTie,
	input wire logic anaTempSel,
	input wire logic anaBandgapSel,
	input wire logic anaRefHiSel,
	input wire logic anaRefLoSel,
	input wire logic adcPowered,
	input wire logic bgBufEn,
	// Comparator
	input wire logic [RES_W-1:0] dacCode,
	output logic compIn
);
	logic [RES_W-1:0] level;
	logic known;
	logic noise = 1'b0;

	// Unselected input floats, so the comparator toggles every cycle
	always @(posedge ref_clk) begin
		noise <= ~noise;
	end

	// Source level on the converter input
	always_comb begin
		level = 10'h000;
		known = 1'b0;
		for (int i = 0; i < NPIN; i++) begin
			if (anaPinSel[i]) begin
				level = 10'h025 + 10'(i) * 10'h070;
				known = 1'b1;
			end
		end
		if (anaTempSel) begin
			level = TEMP_LVL;
			known = 1'b1;
		end
		if (anaBandgapSel && bgBufEn) begin
			level = BG_LVL;
			known = 1'b1;
		end
		if (anaRefHiSel) begin
			level = 10'h3FF;
			known = 1'b1;
		end
		if (anaGndTie || anaRefLoSel) begin
			known = 1'b1;
		end
		compIn = (adcPowered && known) ? (level >= dacCode) : noise;
	end
endmodule

// >>> test/adc_channel_select_decode_tb.sv
// Register level bench for the converter channel select block
`timescale 1ns/10ps
module adc_channel_select_decode_tb;
	import acs_pkg::*;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, compIn;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdat;
	logic [NPIN-1:0] anaPinSel, pinDigDisable;
	logic anaGndTie, anaTempSel, anaBandgapSel, anaRefHiSel, anaRefLoSel, adcPowered, bgBufEn, convBusy, err;
	logic [RES_W-1:0] dacCode;
	int badCount = 0;
	int nCompared = 0;

	acs_top acs_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.anaPinSel(anaPinSel), .anaGndTie(anaGndTie), .anaTempSel(anaTempSel), .anaBandgapSel(anaBandgapSel),
		.anaRefHiSel(anaRefHiSel), .anaRefLoSel(anaRefLoSel), .adcPowered(adcPowered), .bgBufEn(bgBufEn),
		.pinDigDisable(pinDigDisable), .compIn(compIn), .dacCode(dacCode), .convBusy(convBusy));

	acs_analog_model acs_analog_model_i (.ref_clk(ref_clk), .anaPinSel(anaPinSel), .anaGndTie(anaGndTie),
		.anaTempSel(anaTempSel), .anaBandgapSel(anaBandgapSel), .anaRefHiSel(anaRefHiSel),
		.anaRefLoSel(anaRefLoSel), .adcPowered(adcPowered), .bgBufEn(bgBufEn), .dacCode(dacCode), .compIn(compIn));

	// 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Verdict and end of run
	task automatic testDone();
		if (badCount == 0 && nCompared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		nCompared++;
		if (seen !== exp) begin
			badCount++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			badCount++;
			testDone();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Poll the done flag with a bounded count
	task automatic waitDone();
		int k;
		k = 0;
		do begin
			apb(1'b0, OFS_STATCTRL, 32'h0);
			k++;
		end while (rdat[SC_DONE_BIT] !== 1'b1 && k < 300);
		if (rdat[SC_DONE_BIT] !== 1'b1) begin
			badCount++;
			testDone();
		end
	endtask

	// Start a conversion on one channel and compare its result
	task automatic conv(input logic [CH_W-1:0] ch, input logic [RES_W-1:0] exp);
		apb(1'b1, OFS_STATCTRL, 32'(ch));
		waitDone();
		apb(1'b0, OFS_RESULT, 32'h0);
		chk("result", rdat, 32'(exp));
	endtask

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		chk("powered at reset", 32'(adcPowered), 32'h0);
		chk("pin disable at reset", 32'(pinDigDisable), 32'(RST_PINCTL));
		apb(1'b0, OFS_STATCTRL, 32'h0);
		chk("channel at reset", rdat & 32'h1F, 32'h1F);
		for (int i = 0; i < NPIN; i++) begin
			conv(5'(i), 10'h025 + 10'(i) * 10'h070);
			chk("pin select", 32'(anaPinSel), 32'h1 << i);
		end
		// Trigger setting must not launch anything while idle on a pin
		apb(1'b1, OFS_TRIGCTL, 32'h1);
		repeat (40) @(posedge ref_clk);
		chk("busy after trigger", 32'(convBusy), 32'h0);
		apb(1'b0, OFS_STATCTRL, 32'h0);
		chk("done after trigger", 32'(rdat[SC_DONE_BIT]), 32'h0);
		for (int i = 8; i < 20; i++) begin
			conv(5'(i), 10'h000);
			chk("ground tie", 32'(anaGndTie), 32'h1);
		end
		conv(CH_TEMP, 10'h155);
		chk("temp select", 32'(anaTempSel), 32'h1);
		apb(1'b1, OFS_PWRCTL, 32'h1);
		@(posedge ref_clk);
		chk("buffer enable", 32'(bgBufEn), 32'h1);
		conv(CH_BANDGAP, 10'h2AA);
		chk("bandgap select", 32'(anaBandgapSel), 32'h1);
		conv(CH_REF_HI, 10'h3FF);
		chk("ref high select", 32'(anaRefHiSel), 32'h1);
		conv(CH_REF_LO, 10'h000);
		chk("ref low select", 32'(anaRefLoSel), 32'h1);
		// Reserved code: result undefined, only that no pin, ground, temperature or reference source is routed
		apb(1'b1, OFS_STATCTRL, 32'h14);
		waitDone();
		chk("reserved routing", 32'({anaPinSel, anaGndTie, anaTempSel, anaRefHiSel, anaRefLoSel}), 32'h0);
		// Restart mid conversion lands the second channel
		apb(1'b1, OFS_STATCTRL, 32'h7);
		repeat (30) @(posedge ref_clk);
		chk("busy mid run", 32'(convBusy), 32'h1);
		conv(5'h02, 10'h105);
		// Continuous mode on channel 3 repeats without further writes
		apb(1'b1, OFS_STATCTRL, 32'h23);
		waitDone();
		chk("continuous bit", 32'(rdat[SC_CONT_BIT]), 32'h1);
		apb(1'b0, OFS_RESULT, 32'h0);
		chk("continuous first", rdat, 32'h175);
		waitDone();
		apb(1'b0, OFS_RESULT, 32'h0);
		chk("continuous repeat", rdat, 32'h175);
		chk("busy on repeat", 32'(convBusy), 32'h1);
		// Disable code lands while the repeat is running
		apb(1'b1, OFS_STATCTRL, 32'(CH_OFF));
		repeat (4) @(posedge ref_clk);
		chk("powered when off", 32'(adcPowered), 32'h0);
		chk("busy when off", 32'(convBusy), 32'h0);
		apb(1'b1, OFS_PINCTL1, 32'hA5);
		@(posedge ref_clk);
		chk("pin disable", 32'(pinDigDisable), 32'hA5);
		apb(1'b1, OFS_PINCTL4, 32'hFF);
		chk("fourth ctl error", 32'(err), 32'h0);
		@(posedge ref_clk);
		chk("pins after fourth", 32'(pinDigDisable), 32'hA5);
		apb(1'b0, OFS_PINCTL4, 32'h0);
		chk("fourth ctl read", rdat, 32'h0);
		apb(1'b1, OFS_PINCTL2, 32'hFF);
		apb(1'b0, OFS_PINCTL2, 32'h0);
		chk("absent ctl two", rdat, 32'h0);
		apb(1'b0, OFS_PINCTL3, 32'h0);
		chk("absent ctl three", rdat, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'(err), 32'h1);
		chk("unmapped data", rdat, 32'h0);
		testDone();
	end
endmodule
